// ### design/gisc_pkg.sv
// package of constants and carrier types for the guard interlock output control
package gisc_pkg;
	// clock rate and feedback timing
	localparam int CLK_HZ = 20000000;
	localparam int FB_OPEN_MS = 500;
	// longest time rounds down to whole cycles
	localparam int FB_OPEN_CYC = (FB_OPEN_MS * (CLK_HZ / 1000));
	localparam int CNT_W = 24;
	// register map over apb
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STAT = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;
	// control field positions
	localparam int CTRL_FB_EN_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
	// event bit positions
	localparam int EV_OFF_BIT = 0;
	localparam int EV_ON_BIT = 1;
	localparam int EV_FB_STATE_BIT = 2;
	localparam int EV_FB_TIME_BIT = 3;
	localparam int EV_W = 4;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_ON_WAIT = 2'b01,
		ST_ON = 2'b10,
		ST_FAULT = 2'b11
	} gisc_state_t;

	// sensing inputs after synchronising
	typedef struct packed {
		logic in_range;
		logic chain_a;
		logic chain_b;
		logic feedback;
	} gisc_sense_t;

	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} gisc_apb_req_t;
endpackage

// ### design/gisc_ctrl.sv
// safety output controller for a non-contact guard interlock sensor
// Function
// RULE1: guard opened beyond release distance switches both safety outputs off.
// RULE2: without feedback monitoring, guard closure within operate distance turns outputs on.
// RULE3: with feedback monitoring, closure re-enables outputs only when feedback is correct.
// RULE4: feedback reads closed while outputs are off and open while on, and is checked.
// RULE5: after outputs switch on the feedback must open within 500 ms, which is checked.
// RULE6: the outside party feeds feedback through the series closed contacts of both contactors.
// RULE7: without monitoring the feedback input is tied high and contacts are not checked; ST_ON_WAIT still times out to ST_FAULT with monitoring off.
// RULE8: in a chain each sensor's outputs drive the chain inputs of the preceding sensor.
// RULE9: a deactivated sensor upstream in the chain switches this sensor's outputs off.
// RULE10: a chain holds at most 16 sensors in series.
// RULE11: only the first sensor of a chain monitors feedback; others tie it high.
// RULE12: the status output shows the current on or off condition of the safety outputs.
// RULE13: outputs are enabled only with both chain inputs high, in range and feedback ok.
// RULE14: a feedback state or timing fault forces outputs off until feedback is correct.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module gisc_ctrl (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic actuator_in_range,
	input wire logic chain_input_a,
	input wire logic chain_input_b,
	input wire logic contactor_feedback_input,
	input wire gisc_pkg::gisc_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic safety_output_a,
	output logic safety_output_b,
	output logic status_output,
	output logic irq
);
	import gisc_pkg::*;

	gisc_sense_t meta_q;
	gisc_sense_t sense_q;
	gisc_state_t state_q;
	logic [CNT_W-1:0] fb_cnt_q;
	logic [31:0] ctrl_q;
	logic [EV_W-1:0] irq_stat_q;
	logic [EV_W-1:0] irq_mask_q;
	logic [EV_W-1:0] ev_d;
	logic fb_en;
	logic permit;
	logic fb_closed_ok;
	logic wr_acc;
	logic rd_acc;

	// register offset decode, used only for the error flag on unmapped offsets
	function automatic logic addr_mapped(input logic [11:0] a);
		if (a == ADDR_CTRL) begin
			return 1'b1;
		end else if (a == ADDR_STAT) begin
			return 1'b1;
		end else if (a == ADDR_IRQ_STAT) begin
			return 1'b1;
		end else if (a == ADDR_IRQ_MASK) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction

	// two-stage synchroniser on every sensing input; only stage two is read
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			sense_q <= '0;
		end else begin
			meta_q <= '{actuator_in_range, chain_input_a, chain_input_b,
				contactor_feedback_input};
			sense_q <= meta_q;
		end
	end

	// feedback monitoring off treats the tied-high input as don't care
	assign fb_en = ctrl_q[CTRL_FB_EN_BIT]; // RULE7 RULE11
	assign fb_closed_ok = !fb_en || sense_q.feedback; // RULE3 RULE4
	assign permit = sense_q.in_range && sense_q.chain_a && sense_q.chain_b; // RULE13 RULE9

	// output state machine; off is the safe default for every unlisted case
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_OFF;
		end else begin
			case (state_q)
				ST_OFF: begin
					if (fb_en && !sense_q.feedback) begin
						state_q <= ST_FAULT; // RULE4 RULE14
					end else if (permit && fb_closed_ok) begin
						state_q <= fb_en ? ST_ON_WAIT : ST_ON; // RULE2 RULE3 RULE13
					end
				end
				ST_ON_WAIT: begin
					if (!permit) begin
						state_q <= ST_OFF; // RULE1 RULE9
					end else if (!sense_q.feedback) begin
						state_q <= ST_ON;
					end else if (fb_cnt_q >= CNT_W'(FB_OPEN_CYC - 1)) begin
						state_q <= ST_FAULT; // RULE5 RULE14
					end
				end
				ST_ON: begin
					if (!permit) begin
						state_q <= ST_OFF; // RULE1 RULE9
					end else if (fb_en && sense_q.feedback) begin
						state_q <= ST_FAULT; // RULE4 RULE14
					end
				end
				default: begin
					// stays off until contacts read closed again or monitoring is switched off
					if (!fb_en || sense_q.feedback) begin
						state_q <= ST_OFF; // RULE14
					end
				end
			endcase
		end
	end

	// feedback open-time counter runs only while waiting for contacts to open
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fb_cnt_q <= '0;
		end else if (state_q == ST_ON_WAIT) begin
			fb_cnt_q <= fb_cnt_q + CNT_W'(1); // RULE5
		end else begin
			fb_cnt_q <= '0;
		end
	end

	// outputs registered from the current state, both channels identical
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			safety_output_a <= 1'b0;
			safety_output_b <= 1'b0;
			status_output <= 1'b0;
		end else begin
			safety_output_a <= (state_q == ST_ON_WAIT) || (state_q == ST_ON); // RULE1 RULE2
			safety_output_b <= (state_q == ST_ON_WAIT) || (state_q == ST_ON); // RULE1 RULE2
			status_output <= (state_q == ST_ON_WAIT) || (state_q == ST_ON); // RULE12
		end
	end

	// event pulses: off, on, feedback state fault, feedback timeout
	always_comb begin
		ev_d = '0;
		ev_d[EV_OFF_BIT] = safety_output_a && !((state_q == ST_ON_WAIT) || (state_q == ST_ON));
		ev_d[EV_ON_BIT] = !safety_output_a && ((state_q == ST_ON_WAIT) || (state_q == ST_ON));
		ev_d[EV_FB_STATE_BIT] = fb_en && (((state_q == ST_OFF) && !sense_q.feedback) ||
			((state_q == ST_ON) && permit && sense_q.feedback));
		ev_d[EV_FB_TIME_BIT] = (state_q == ST_ON_WAIT) && permit && sense_q.feedback &&
			(fb_cnt_q >= CNT_W'(FB_OPEN_CYC - 1));
	end

	// apb slave: zero wait states, access phase always ready
	assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd_acc = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

	// control register, writable only at mapped offset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_acc && apb_req.paddr == ADDR_CTRL) begin
			ctrl_q <= {31'h00000000, apb_req.pwdata[CTRL_FB_EN_BIT]};
		end
	end

	// mask register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_mask_q <= IRQ_MASK_RESET;
		end else if (wr_acc && apb_req.paddr == ADDR_IRQ_MASK) begin
			irq_mask_q <= apb_req.pwdata[EV_W-1:0];
		end
	end

	// sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_q <= '0;
		end else if (wr_acc && apb_req.paddr == ADDR_IRQ_STAT) begin
			irq_stat_q <= (irq_stat_q & ~apb_req.pwdata[EV_W-1:0]) | ev_d;
		end else begin
			irq_stat_q <= irq_stat_q | ev_d;
		end
	end

	// interrupt level registered from the masked status
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	// read data captured in setup so it is stable during the access phase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= '0;
		end else if (rd_acc) begin
			if (apb_req.paddr == ADDR_CTRL) begin
				prdata <= ctrl_q;
			end else if (apb_req.paddr == ADDR_STAT) begin
				prdata <= {24'h000000, sense_q, state_q, status_output, safety_output_a};
			end else if (apb_req.paddr == ADDR_IRQ_STAT) begin
				prdata <= {28'h0000000, irq_stat_q};
			end else if (apb_req.paddr == ADDR_IRQ_MASK) begin
				prdata <= {28'h0000000, irq_mask_q};
			end else begin
				prdata <= '0;
			end
		end
	end

	// ready and error flag, raised for the single access cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_req.psel && !apb_req.penable;
			pslverr <= apb_req.psel && !apb_req.penable && !addr_mapped(apb_req.paddr);
		end
	end

	// outputs never on without both chain inputs and range seen a cycle earlier
	chk_outputs_need_permit: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(safety_output_a) |-> $past(permit)) // RULE13
		else $error("outputs rose without permit");
	chk_guard_open_off: assert property (@(posedge clk) disable iff (!reset_n)
		(!permit && safety_output_a) |-> ##[1:2] !safety_output_a) // RULE1
		else $error("outputs not off after guard open");
	chk_chain_drop_off: assert property (@(posedge clk) disable iff (!reset_n)
		(!sense_q.chain_a || !sense_q.chain_b) |-> ##2 !safety_output_b) // RULE9
		else $error("chain drop did not clear outputs");
	chk_auto_reenable: assert property (@(posedge clk) disable iff (!reset_n)
		(!fb_en && permit && state_q == ST_OFF) |=> ##1 safety_output_a) // RULE2
		else $error("no reenable without monitoring");
	chk_fb_gate_on: assert property (@(posedge clk) disable iff (!reset_n)
		(fb_en && state_q == ST_OFF && !sense_q.feedback) |=> state_q == ST_FAULT) // RULE3 RULE4
		else $error("outputs allowed with wrong feedback");
	chk_fb_timeout: assert property (@(posedge clk) disable iff (!reset_n)
		(state_q == ST_ON_WAIT) |-> fb_cnt_q < CNT_W'(FB_OPEN_CYC)) // RULE5
		else $error("feedback wait exceeded limit");
	chk_fault_holds_off: assert property (@(posedge clk) disable iff (!reset_n)
		(state_q == ST_FAULT) |=> !safety_output_a && !safety_output_b) // RULE14
		else $error("outputs on during fault");
	chk_status_mirror: assert property (@(posedge clk) disable iff (!reset_n)
		status_output == safety_output_a && safety_output_a == safety_output_b) // RULE12
		else $error("status or channels disagree");
	chk_nomon_no_fault: assert property (@(posedge clk) disable iff (!reset_n)
		(!fb_en && state_q != ST_FAULT) |=> state_q != ST_FAULT) // RULE7
		else $error("fault entered without monitoring");

	// register bus: setup is always answered by ready in the very next cycle
	chk_ready_after_setup: assert property (@(posedge clk) disable iff (!reset_n)
		(apb_req.psel && !apb_req.penable) |=> pready)
		else $error("ready missing after setup");
	// ready lasts one cycle, so a held access is never answered twice
	chk_ready_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
		pready |=> !pready)
		else $error("ready held too long");
	// unmapped offsets answer with an error flag
	chk_err_unmapped: assert property (@(posedge clk) disable iff (!reset_n)
		(apb_req.psel && !apb_req.penable && !addr_mapped(apb_req.paddr)) |=> pslverr)
		else $error("no error on unmapped offset");
	// error flag only ever rides along with ready
	chk_err_with_ready: assert property (@(posedge clk) disable iff (!reset_n)
		pslverr |-> pready)
		else $error("error flag without ready");
	// read data must not move outside a read setup
	chk_rdata_holds: assert property (@(posedge clk) disable iff (!reset_n)
		!rd_acc |=> $stable(prdata))
		else $error("read data moved");
	// monitoring enable follows the written bit
	chk_ctrl_write: assert property (@(posedge clk) disable iff (!reset_n)
		(wr_acc && apb_req.paddr == ADDR_CTRL) |=>
		ctrl_q[CTRL_FB_EN_BIT] == $past(apb_req.pwdata[CTRL_FB_EN_BIT])) // RULE7
		else $error("control write lost");
	// unused control bits always read zero
	chk_ctrl_upper_zero: assert property (@(posedge clk) disable iff (!reset_n)
		ctrl_q[31:1] == 31'h00000000)
		else $error("unused control bits set");
	// mask register takes the written value
	chk_mask_write: assert property (@(posedge clk) disable iff (!reset_n)
		(wr_acc && apb_req.paddr == ADDR_IRQ_MASK) |=>
		irq_mask_q == $past(apb_req.pwdata[EV_W-1:0]))
		else $error("mask write lost");
	// an event always lands in status, even against a clear in the same cycle
	chk_event_sets: assert property (@(posedge clk) disable iff (!reset_n)
		(|ev_d) |=> ((irq_stat_q & $past(ev_d)) == $past(ev_d)))
		else $error("event not recorded");
	// status bits only drop through a write to the status register
	chk_status_sticky: assert property (@(posedge clk) disable iff (!reset_n)
		!(wr_acc && apb_req.paddr == ADDR_IRQ_STAT) |=>
		((irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q)))
		else $error("status bit lost");
	// writing ones clears exactly those bits when no event competes
	chk_w1c_clear: assert property (@(posedge clk) disable iff (!reset_n)
		(wr_acc && apb_req.paddr == ADDR_IRQ_STAT && ev_d == '0) |=>
		irq_stat_q == ($past(irq_stat_q) & ~$past(apb_req.pwdata[EV_W-1:0])))
		else $error("clear did not act");
	// interrupt line is the masked status one cycle late
	chk_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
		irq == $past(|(irq_stat_q & irq_mask_q)))
		else $error("interrupt level wrong");
	// logic reads only the second synchroniser stage
	chk_sync_stage: assert property (@(posedge clk) disable iff (!reset_n)
		sense_q == $past(meta_q))
		else $error("synchroniser skipped a stage");
	// outputs follow the state one cycle later, never from the raw inputs
	chk_out_from_state: assert property (@(posedge clk) disable iff (!reset_n)
		safety_output_a == $past((state_q == ST_ON_WAIT) || (state_q == ST_ON))) // RULE13
		else $error("output not from state");
	// losing range or a chain input leaves either on state for off
	chk_drop_to_off: assert property (@(posedge clk) disable iff (!reset_n)
		((state_q == ST_ON_WAIT || state_q == ST_ON) && !permit) |=> state_q == ST_OFF) // RULE1 RULE9
		else $error("on state kept without permit");
	// closed contacts while on is a welded contactor
	chk_on_fb_stuck: assert property (@(posedge clk) disable iff (!reset_n)
		(state_q == ST_ON && permit && fb_en && sense_q.feedback) |=> state_q == ST_FAULT) // RULE4
		else $error("closed feedback while on not caught");
	// contacts opening in time completes the switch on
	chk_wait_opens: assert property (@(posedge clk) disable iff (!reset_n)
		(state_q == ST_ON_WAIT && permit && !sense_q.feedback) |=> state_q == ST_ON) // RULE5
		else $error("open feedback not accepted");
	// with monitoring the outputs go on through the timed wait
	chk_mon_wait: assert property (@(posedge clk) disable iff (!reset_n)
		(fb_en && permit && fb_closed_ok && state_q == ST_OFF) |=> state_q == ST_ON_WAIT) // RULE3
		else $error("monitored switch on skipped wait");
	// without monitoring closure switches straight on
	chk_nomon_on: assert property (@(posedge clk) disable iff (!reset_n)
		(!fb_en && permit && state_q == ST_OFF) |=> state_q == ST_ON) // RULE2 RULE7
		else $error("unmonitored switch on missing");
	// a fault ends once the contacts read closed again or monitoring is off
	chk_fault_exit: assert property (@(posedge clk) disable iff (!reset_n)
		(state_q == ST_FAULT && (!fb_en || sense_q.feedback)) |=> state_q == ST_OFF) // RULE14
		else $error("fault not left on correct feedback");
	// open-time counter is cleared outside the wait and counts inside it
	chk_cnt_idle: assert property (@(posedge clk) disable iff (!reset_n)
		(state_q != ST_ON_WAIT) |=> fb_cnt_q == '0) // RULE5
		else $error("counter not cleared");
	chk_cnt_counts: assert property (@(posedge clk) disable iff (!reset_n)
		(state_q == ST_ON_WAIT) |=> fb_cnt_q == $past(fb_cnt_q) + CNT_W'(1)) // RULE5
		else $error("counter did not advance");

	cov_fault_exit: cover property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_FAULT ##1 state_q == ST_OFF);
	cov_on_auto: cover property (@(posedge clk) disable iff (!reset_n)
		!fb_en ##1 $rose(safety_output_a));
	cov_on_fb: cover property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_ON_WAIT ##1 state_q == ST_ON);
	cov_timeout: cover property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_ON_WAIT ##1 state_q == ST_FAULT);
	cov_irq: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq));
endmodule

// ### testbench/gisc_contactors.sv
// model of the contactor pair whose closed contacts feed the feedback input
`timescale 1ns/1ps
module gisc_contactors #(
	parameter int OPEN_DLY = 20
) (
	input wire logic clk,
	input wire logic coil_a,
	input wire logic coil_b,
	input wire logic [1:0] fault_mode,
	output logic feedback
);
	logic [7:0] dly_q = 8'h00;
	// count cycles since both coils pulled in; saturate so a long on time never wraps
	always @(posedge clk) begin
		if (!(coil_a && coil_b)) begin
			dly_q <= 8'h00;
		end else if (dly_q != 8'hff) begin
			dly_q <= dly_q + 8'h01;
		end
	end
	// series closed contacts: closed while off, open well inside the limit once on
	// mode 1 is a welded contact, mode 2 a contact stuck open
	assign feedback = (fault_mode == 2'h2) ? 1'b0 : (fault_mode == 2'h1) ? 1'b1 :
		(dly_q < 8'(OPEN_DLY));
endmodule

// ### testbench/gate_interlock_safety_output_ctrl_bench.sv
// self-checking bench for the guard interlock safety output controller
`timescale 1ns/1ps
module gate_interlock_safety_output_ctrl_bench;
	import gisc_pkg::*;
	logic clk, reset_n, in_rng, ch_a, ch_b, fb_tie, fb_dev, fb_mod, out_a, out_b, stat_o, irq;
	logic pready, pslverr, err;
	logic [1:0] fmode;
	logic [31:0] prdata, d;
	logic [3:0] rows [6];
	gisc_apb_req_t req;
	int error_cnt, comparisons, i;
	// a tied feedback input stands for the wiring without monitoring
	assign fb_dev = fb_tie ? 1'b1 : fb_mod;
	gisc_ctrl gisc_ctrl_i (.clk(clk), .reset_n(reset_n), .actuator_in_range(in_rng),
		.chain_input_a(ch_a), .chain_input_b(ch_b), .contactor_feedback_input(fb_dev),
		.apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.safety_output_a(out_a), .safety_output_b(out_b), .status_output(stat_o), .irq(irq));
	gisc_contactors gisc_contactors_i (.clk(clk), .coil_a(out_a), .coil_b(out_b),
		.fault_mode(fmode), .feedback(fb_mod));
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic give_verdict();
		$display("counts: %0d compared, %0d mismatched", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic done(input string s);
		$display("test %s finished, %0d mismatches so far", s, error_cnt);
	endtask
	// one apb transfer, entered just after an edge; read data and error land in d and err
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		// look at settled values just before the edge that samples them
		do begin
			@(negedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			$display("BAD pready expected 1 seen %b", pready);
			give_verdict();
		end
		d = prdata;
		err = pslverr;
		@(posedge clk);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		// one idle edge so a following call never reassigns in the same step
		@(posedge clk);
	endtask
	// bounded wait for the outputs to reach a level, then both copies and status agree
	task automatic wait_out(input logic e);
		int n;
		n = 0;
		while (out_a !== e && n < 12) begin
			@(posedge clk);
			n++;
		end
		if (n >= 12) begin
			error_cnt++;
			$display("BAD output a expected %b seen %b", e, out_a);
			give_verdict();
		end
		check("output b", 32'(e), 32'(out_b));
		check("status", 32'(e), 32'(stat_o));
	endtask
	// output a must still be at the level after a stretch of 40 cycles
	task automatic hold(input logic e);
		repeat (40) @(posedge clk);
		check("held output", 32'(e), 32'(out_a));
	endtask
	// hang guard well above the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		$display("BAD run length expected end seen timeout");
		give_verdict();
	end
	initial begin
		reset_n = 1'b0;
		in_rng = 1'b0;
		ch_a = 1'b1;
		ch_b = 1'b1;
		fb_tie = 1'b1;
		fmode = 2'h0;
		req = '0;
		error_cnt = 0;
		comparisons = 0;
		// guard in range, chain a, chain b, expected outputs
		rows = '{4'b1111, 4'b0110, 4'b1111, 4'b1010, 4'b1111, 4'b1100};
		repeat (8) @(posedge clk);
		check("reset output", 32'h0, 32'(out_a));
		reset_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, ADDR_CTRL, 32'h0);
		check("ctrl reset", CTRL_RESET, d);
		apb(1'b0, ADDR_IRQ_MASK, 32'h0);
		check("mask reset", 32'(IRQ_MASK_RESET), d);
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped err", 32'h1, 32'(err));
		check("unmapped data", 32'h0, d);
		done("reset");
		for (i = 0; i < 6; i++) begin
			{in_rng, ch_a, ch_b} <= rows[i][3:1];
			@(posedge clk);
			wait_out(rows[i][0]);
		end
		done("rows");
		// events were logged while masked, so the line stays low until unmasked
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		check("events seen", 32'h3, d);
		check("masked irq", 32'h0, 32'(irq));
		apb(1'b1, ADDR_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk);
		check("irq raised", 32'h1, 32'(irq));
		apb(1'b1, ADDR_IRQ_STAT, 32'hf);
		repeat (2) @(posedge clk);
		check("irq cleared", 32'h0, 32'(irq));
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		check("events cleared", 32'h0, d);
		done("irq");
		apb(1'b1, ADDR_CTRL, 32'h1);
		apb(1'b0, ADDR_CTRL, 32'h0);
		check("ctrl", 32'h1, d);
		fb_tie <= 1'b0;
		ch_b <= 1'b1;
		in_rng <= 1'b1;
		wait_out(1'b1);
		hold(1'b1);
		in_rng <= 1'b0;
		wait_out(1'b0);
		fmode <= 2'h2;
		in_rng <= 1'b1;
		hold(1'b0);
		fmode <= 2'h0;
		wait_out(1'b1);
		hold(1'b1);
		// contacts weld shut while on
		fmode <= 2'h1;
		wait_out(1'b0);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		check("state fault", 32'h1, 32'(d[EV_FB_STATE_BIT]));
		done("monitoring");
		in_rng <= 1'b0;
		fmode <= 2'h0;
		wait_out(1'b0);
		hold(1'b0);
		apb(1'b1, ADDR_CTRL, 32'h0);
		fmode <= 2'h2;
		in_rng <= 1'b1;
		wait_out(1'b1);
		hold(1'b1);
		done("no monitoring");
		give_verdict();
	end
endmodule
